// *** touch_adc_pkg.sv ***
/*
  Constants and types shared by the touch/auxiliary converter sequencer.
  Assumes a 200 MHz system clock; every cycle count is derived from it.
*/
package touch_adc_pkg;

  localparam int CLK_MHZ = 200;

  // Control word field positions.
  localparam int BIT_MODE   = 15;
  localparam int BIT_STOP   = 14;
  localparam int FUNC_LSB   = 10;
  localparam int RES_LSB    = 8;
  localparam int AVG_LSB    = 6;
  localparam int CCLK_LSB   = 4;
  localparam int SETTLE_LSB = 1;

  // Values after reset.
  localparam logic       MODE_RST   = 1'b0;
  localparam logic [3:0] FUNC_RST   = 4'h0;
  localparam logic [1:0] RES_RST    = 2'h0;
  localparam logic [1:0] AVG_RST    = 2'h0;
  localparam logic [1:0] CCLK_RST   = 2'h0;
  localparam logic [2:0] SETTLE_RST = 3'h0;

  // Function select codes.
  localparam logic [3:0] FN_INVALID = 4'h0;
  localparam logic [3:0] FN_XY      = 4'h1;
  localparam logic [3:0] FN_XYZ     = 4'h2;
  localparam logic [3:0] FN_X       = 4'h3;
  localparam logic [3:0] FN_Y       = 4'h4;
  localparam logic [3:0] FN_Z       = 4'h5;
  localparam logic [3:0] FN_BATTERY_ONE_RESULT    = 4'h6;
  localparam logic [3:0] FN_BATTERY_TWO_RESULT    = 4'h7;
  localparam logic [3:0] FN_AUXILIARY_ONE_RESULT    = 4'h8;
  localparam logic [3:0] FN_AUXILIARY_TWO_RESULT    = 4'h9;
  localparam logic [3:0] FN_TEMP1   = 4'hA;
  localparam logic [3:0] FN_PORT    = 4'hB;
  localparam logic [3:0] FN_TEMP2   = 4'hC;
  localparam logic [3:0] FN_DRV_X   = 4'hD;
  localparam logic [3:0] FN_DRV_Y   = 4'hE;
  localparam logic [3:0] FN_DRV_YX  = 4'hF;

  typedef enum logic [3:0] {
    CH_X, CH_Y, CH_Z1, CH_Z2, CH_BATTERY_ONE_RESULT, CH_BATTERY_TWO_RESULT,
    CH_AUXILIARY_ONE_RESULT, CH_AUXILIARY_TWO_RESULT, CH_TEMP1, CH_TEMP2
  } channel_t;

  // Conversion clock rates and the system-clock divisors they imply.
  localparam int CCLK_MHZ_0 = 8;
  localparam int CCLK_MHZ_1 = 4;
  localparam int CCLK_MHZ_2 = 2;
  localparam int CCLK_MHZ_3 = 1;
  localparam logic [7:0] CCLK_DIV_0 = 8'(CLK_MHZ / CCLK_MHZ_0);
  localparam logic [7:0] CCLK_DIV_1 = 8'(CLK_MHZ / CCLK_MHZ_1);
  localparam logic [7:0] CCLK_DIV_2 = 8'(CLK_MHZ / CCLK_MHZ_2);
  localparam logic [7:0] CCLK_DIV_3 = 8'(CLK_MHZ / CCLK_MHZ_3);
  // Conversion clocks spent on sampling beyond one per result bit.
  localparam logic [4:0] CONV_OVERHEAD = 5'h04;

  // Panel settling times in microseconds and in system clocks.
  localparam int SETTLE_US_1 = 100;
  localparam int SETTLE_US_2 = 500;
  localparam int SETTLE_US_3 = 1000;
  localparam int SETTLE_US_4 = 5000;
  localparam int SETTLE_US_5 = 10000;
  localparam int SETTLE_US_6 = 50000;
  localparam int SETTLE_US_7 = 100000;
  localparam int SETTLE_CYC_1 = SETTLE_US_1 * CLK_MHZ;
  localparam int SETTLE_CYC_2 = SETTLE_US_2 * CLK_MHZ;
  localparam int SETTLE_CYC_3 = SETTLE_US_3 * CLK_MHZ;
  localparam int SETTLE_CYC_4 = SETTLE_US_4 * CLK_MHZ;
  localparam int SETTLE_CYC_5 = SETTLE_US_5 * CLK_MHZ;
  localparam int SETTLE_CYC_6 = SETTLE_US_6 * CLK_MHZ;
  localparam int SETTLE_CYC_7 = SETTLE_US_7 * CLK_MHZ;
  localparam int SETTLE_W     = 25;

endpackage

// *** settle_timer.sv ***
/*
  One-shot delay for panel settling.
  Assumes start is a one-cycle pulse; a new start restarts the count.
*/
`timescale 1ns/1ps
module settle_timer
  import touch_adc_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                start,
  input  wire logic [SETTLE_W-1:0] cycles,
  input  wire logic                abort,
  output logic                     done
);
  logic [SETTLE_W-1:0] cnt_q, cnt_d;
  logic                run_q, run_d;

  // The done pulse comes cycles+1 edges after start, never early.
  assign done = run_q && (cnt_q == '0);

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    // A write that starts a new sequence also aborts the old one, so the
    // start must win or the new sequence would never begin.
    if (start) begin
      cnt_d = cycles;
      run_d = 1'b1;
    end else if (abort) begin
      run_d = 1'b0;
    end else if (done) begin
      run_d = 1'b0;
    end else if (run_q) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end
endmodule // settle_timer

// *** conv_timer.sv ***
/*
  Times one conversion: ticks periods of a conversion clock made by
  dividing the system clock by div. Assumes div and ticks are nonzero.
*/
`timescale 1ns/1ps
module conv_timer (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] div,
  input  wire logic [4:0] ticks,
  input  wire logic       abort,
  output logic            done
);
  logic [7:0] pre_q, pre_d, div_q, div_d;
  logic [4:0] tk_q, tk_d;
  logic       run_q, run_d;

  assign done = run_q && (pre_q == '0) && (tk_q == '0);

  always_comb begin
    pre_d = pre_q;
    div_d = div_q;
    tk_d  = tk_q;
    run_d = run_q;
    // Start wins over abort, since a starting write also raises abort.
    if (start) begin
      div_d = div;
      pre_d = div - 8'h01;
      tk_d  = ticks - 5'h01;
      run_d = 1'b1;
    end else if (abort) begin
      run_d = 1'b0;
    end else if (done) begin
      run_d = 1'b0;
    end else if (run_q) begin
      if (pre_q == '0) begin
        pre_d = div_q - 8'h01;
        tk_d  = tk_q - 5'h01;
      end else begin
        pre_d = pre_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_q <= '0;
      div_q <= '0;
      tk_q  <= '0;
      run_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      div_q <= div_d;
      tk_q  <= tk_d;
      run_q <= run_d;
    end
  end
endmodule // conv_timer

// *** touch_adc_control_sequencer.sv ***
/*
  Control word and measurement sequencer for a shared touch/aux converter.
  Assumes a word-wide register port fed by the serial front end, a pen
  detector pin from outside the clock domain, and a sample value from
  the analog front end that is valid when each conversion ends.
*/
`timescale 1ns/1ps
module touch_adc_control_sequencer
  import touch_adc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC_P1 = SETTLE_CYC_1,
  parameter int unsigned SETTLE_CYC_P2 = SETTLE_CYC_2,
  parameter int unsigned SETTLE_CYC_P3 = SETTLE_CYC_3,
  parameter int unsigned SETTLE_CYC_P4 = SETTLE_CYC_4,
  parameter int unsigned SETTLE_CYC_P5 = SETTLE_CYC_5,
  parameter int unsigned SETTLE_CYC_P6 = SETTLE_CYC_6,
  parameter int unsigned SETTLE_CYC_P7 = SETTLE_CYC_7
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        pen_touch_in,
  input  wire logic [11:0] sample_in,
  output channel_t         conv_channel,
  output logic             adc_power_on,
  output logic             result_available_output,
  output logic             result_we,
  output channel_t         result_sel,
  output logic      [11:0] result_data,
  output logic             drv_xp,
  output logic             drv_xm,
  output logic             drv_yp,
  output logic             drv_ym
);
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONV} state_t;

  function automatic channel_t step_channel(logic [3:0] f, logic [1:0] s);
    unique case (f)
      FN_XY:    return s[0] ? CH_Y : CH_X;
      FN_XYZ:   return channel_t'({2'h0, s});
      FN_Y:     return CH_Y;
      FN_Z:     return s[0] ? CH_Z2 : CH_Z1;
      FN_BATTERY_ONE_RESULT:  return CH_BATTERY_ONE_RESULT;
      FN_BATTERY_TWO_RESULT:  return CH_BATTERY_TWO_RESULT;
      FN_AUXILIARY_ONE_RESULT:  return CH_AUXILIARY_ONE_RESULT;
      FN_AUXILIARY_TWO_RESULT:  return CH_AUXILIARY_TWO_RESULT;
      FN_TEMP1: return CH_TEMP1;
      FN_TEMP2: return CH_TEMP2;
      FN_PORT:  return channel_t'({2'h1, s});
      default:  return CH_X;
    endcase
  endfunction

  function automatic logic [1:0] last_step(logic [3:0] f);
    unique case (f)
      FN_XY, FN_Z:     return 2'h1;
      FN_XYZ, FN_PORT: return 2'h3;
      default:         return 2'h0;
    endcase
  endfunction

  function automatic logic is_scan(logic [3:0] f);
    return (f == FN_XY) || (f == FN_XYZ);
  endfunction

  function automatic logic is_measure(logic [3:0] f);
    return (f != FN_INVALID) && (f < FN_DRV_X);
  endfunction

  function automatic logic drive_ch(channel_t c);
    return c <= CH_Z2;
  endfunction

  // Pen detector synchroniser; a change counts when stages two and three
  // agree, which also filters single-cycle glitches on the pin.
  logic [2:0] pen_s_q, pen_s_d;
  logic       pen_q, pen_d;

  always_comb begin
    pen_s_d = {pen_s_q[1:0], pen_touch_in};
    pen_d   = (pen_s_q[1] == pen_s_q[2]) ? pen_s_q[2] : pen_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pen_s_q <= 3'h0;
      pen_q   <= 1'b0;
    end else begin
      pen_s_q <= pen_s_d;
      pen_q   <= pen_d;
    end
  end

  // Control word fields.
  logic       mode_q, mode_d, stop_q, stop_d;
  logic [3:0] func_q, func_d;
  logic [1:0] res_q, res_d, avg_q, avg_d, cclk_q, cclk_d;
  logic [2:0] settle_q, settle_d;

  always_comb begin
    {mode_d, stop_d, func_d} = {mode_q, stop_q, func_q};
    {res_d, avg_d, cclk_d, settle_d} = {res_q, avg_q, cclk_q, settle_q};
    if (reg_wr) begin
      mode_d   = reg_wdata[BIT_MODE];
      stop_d   = reg_wdata[BIT_STOP];
      func_d   = reg_wdata[FUNC_LSB +: 4];
      res_d    = reg_wdata[RES_LSB +: 2];
      avg_d    = reg_wdata[AVG_LSB +: 2];
      cclk_d   = reg_wdata[CCLK_LSB +: 2];
      settle_d = reg_wdata[SETTLE_LSB +: 3];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_q   <= MODE_RST;
      stop_q   <= 1'b0;
      func_q   <= FUNC_RST;
      res_q    <= RES_RST;
      avg_q    <= AVG_RST;
      cclk_q   <= CCLK_RST;
      settle_q <= SETTLE_RST;
    end else begin
      mode_q   <= mode_d;
      stop_q   <= stop_d;
      func_q   <= func_d;
      res_q    <= res_d;
      avg_q    <= avg_d;
      cclk_q   <= cclk_d;
      settle_q <= settle_d;
    end
  end

  // A write starts its sequence in the same cycle, so the timers take
  // their settings from the incoming word rather than the stale fields.
  logic [1:0]          e_res, e_cclk;
  logic [2:0]          e_settle;
  logic [7:0]          conv_div;
  logic [4:0]          conv_ticks;
  logic [3:0]          res_bits, res_shift;
  logic [SETTLE_W-1:0] settle_cyc;

  always_comb begin
    e_res    = reg_wr ? reg_wdata[RES_LSB +: 2] : res_q;
    e_cclk   = reg_wr ? reg_wdata[CCLK_LSB +: 2] : cclk_q;
    e_settle = reg_wr ? reg_wdata[SETTLE_LSB +: 3] : settle_q;
    unique case (res_q)
      2'h1:    res_bits = 4'h8;
      2'h2:    res_bits = 4'hA;
      default: res_bits = 4'hC;
    endcase
    res_shift = 4'hC - res_bits;
    unique case (e_res)
      2'h1:    conv_ticks = 5'h08 + CONV_OVERHEAD;
      2'h2:    conv_ticks = 5'h0A + CONV_OVERHEAD;
      default: conv_ticks = 5'h0C + CONV_OVERHEAD;
    endcase
    unique case (e_cclk)
      2'h0: conv_div = CCLK_DIV_0;
      2'h1: conv_div = CCLK_DIV_1;
      2'h2: conv_div = CCLK_DIV_2;
      2'h3: conv_div = CCLK_DIV_3;
    endcase
    unique case (e_settle)
      3'h0: settle_cyc = '0;
      3'h1: settle_cyc = SETTLE_W'(SETTLE_CYC_P1);
      3'h2: settle_cyc = SETTLE_W'(SETTLE_CYC_P2);
      3'h3: settle_cyc = SETTLE_W'(SETTLE_CYC_P3);
      3'h4: settle_cyc = SETTLE_W'(SETTLE_CYC_P4);
      3'h5: settle_cyc = SETTLE_W'(SETTLE_CYC_P5);
      3'h6: settle_cyc = SETTLE_W'(SETTLE_CYC_P6);
      3'h7: settle_cyc = SETTLE_W'(SETTLE_CYC_P7);
    endcase
  end

  // Sequencer.
  state_t     state_q, state_d;
  channel_t   chan_q, chan_d, sel_q, sel_d, go_ch;
  logic [1:0] step_q, step_d, go_step;
  logic [3:0] navg_q, navg_d, avg_last, go_func;
  logic [15:0] acc_q, acc_d, sum_now;
  logic [11:0] data_q, data_d;
  logic       armed_q, armed_d, we_q, we_d, go_en;
  logic       settle_go, conv_go, settle_done, conv_done;
  logic       wr_stop, wr_go;

  always_comb begin
    unique case (avg_q)
      2'h0: avg_last = 4'h0;
      2'h1: avg_last = 4'h3;
      2'h2: avg_last = 4'h7;
      2'h3: avg_last = 4'hF;
    endcase
    sum_now = acc_q + 16'(sample_in >> res_shift);
    wr_stop = reg_wr && reg_wdata[BIT_STOP];
    // host control starts at once, self control waits for touch only for scan functions
    wr_go   = reg_wr && !wr_stop && is_measure(reg_wdata[FUNC_LSB +: 4])
              && !(reg_wdata[BIT_MODE] && is_scan(reg_wdata[FUNC_LSB +: 4]));
    state_d = state_q;
    chan_d  = chan_q;
    step_d  = step_q;
    navg_d  = navg_q;
    acc_d   = acc_q;
    armed_d = armed_q;
    we_d    = 1'b0;
    sel_d   = sel_q;
    data_d  = data_q;
    go_en   = 1'b0;
    go_func = func_q;
    go_step = 2'h0;
    settle_go = 1'b0;
    conv_go   = 1'b0;
    go_ch     = CH_X;
    if (reg_wr) begin
      state_d = ST_IDLE;
      step_d  = 2'h0;
      navg_d  = 4'h0;
      acc_d   = '0;
      armed_d = !wr_stop && reg_wdata[BIT_MODE]
                && is_scan(reg_wdata[FUNC_LSB +: 4]);
      go_en   = wr_go;
      go_func = reg_wdata[FUNC_LSB +: 4];
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          go_en = armed_q && pen_q;
        end
        ST_SETTLE: begin
          if (settle_done) begin
            state_d = ST_CONV;
            conv_go = 1'b1;
          end
        end
        ST_CONV: begin
          if (conv_done && navg_q != avg_last) begin
            // stay busy through every averaged conversion
            acc_d   = sum_now;
            navg_d  = navg_q + 4'h1;
            conv_go = 1'b1;
          end else if (conv_done) begin
            we_d    = 1'b1;
            sel_d   = chan_q;
            data_d  = 12'(sum_now);
            if (avg_q != 2'h0) begin
              // Widened so that sixteen samples shift by four, not zero.
              data_d = 12'(sum_now >> ({1'b0, avg_q} + 3'h1));
            end
            acc_d   = '0;
            navg_d  = 4'h0;
            if (step_q != last_step(func_q)) begin
              go_en   = 1'b1;
              go_step = step_q + 2'h1;
            end else if (is_scan(func_q) && pen_q) begin
              // scans repeat while the pen stays down
              go_en   = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
      endcase
    end
    if (go_en) begin
      go_ch  = step_channel(go_func, go_step);
      chan_d = go_ch;
      step_d = go_step;
      if (drive_ch(go_ch)) begin
        state_d   = ST_SETTLE;
        settle_go = 1'b1;
      end else begin
        state_d = ST_CONV;
        conv_go = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_IDLE;
      chan_q  <= CH_X;
      step_q  <= 2'h0;
      navg_q  <= 4'h0;
      acc_q   <= '0;
      armed_q <= 1'b0;
      we_q    <= 1'b0;
      sel_q   <= CH_X;
      data_q  <= 12'h000;
    end else begin
      state_q <= state_d;
      chan_q  <= chan_d;
      step_q  <= step_d;
      navg_q  <= navg_d;
      acc_q   <= acc_d;
      armed_q <= armed_d;
      we_q    <= we_d;
      sel_q   <= sel_d;
      data_q  <= data_d;
    end
  end

  settle_timer u_settle (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (settle_go),
    .cycles  (settle_cyc),
    .abort   (reg_wr),
    .done    (settle_done)
  );

  conv_timer u_conv (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (conv_go),
    .div     (conv_div),
    .ticks   (conv_ticks),
    .abort   (reg_wr),
    .done    (conv_done)
  );

  // Pin-facing outputs and the readback word.
  logic [3:0]  drv_q, drv_d;
  logic        power_q, power_d;
  logic [15:0] rdata_q, rdata_d;

  always_comb begin
    drv_d = 4'h0;
    if (state_d != ST_IDLE) begin
      unique case (chan_d)
        CH_X:         drv_d = 4'b1100;
        CH_Y:         drv_d = 4'b0011;
        CH_Z1, CH_Z2: drv_d = 4'b0110;
        default:      drv_d = 4'h0;
      endcase
    end else if (!stop_d) begin
      unique case (func_d)
        FN_DRV_X:  drv_d = 4'b1100;
        FN_DRV_Y:  drv_d = 4'b0011;
        FN_DRV_YX: drv_d = 4'b0110;
        default:   drv_d = 4'h0;
      endcase
    end
    power_d = state_d != ST_IDLE;
    rdata_d = {pen_q, state_q == ST_IDLE, func_q, res_q, avg_q,
               cclk_q, settle_q, 1'b0};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      drv_q   <= 4'h0;
      power_q <= 1'b0;
      rdata_q <= {MODE_RST, 1'b1, FUNC_RST, RES_RST, AVG_RST,
                  CCLK_RST, SETTLE_RST, 1'b0};
    end else begin
      drv_q   <= drv_d;
      power_q <= power_d;
      rdata_q <= rdata_d;
    end
  end

  assign {drv_xp, drv_xm, drv_yp, drv_ym} = drv_q;
  assign adc_power_on = power_q;
  assign reg_rdata    = rdata_q;
  assign result_we    = we_q;
  assign result_sel   = sel_q;
  assign result_data  = data_q;
  assign conv_channel = chan_q;
  assign result_available_output = state_q == ST_IDLE;

  sequence stop_write;
    reg_wr && reg_wdata[BIT_STOP];
  endsequence

  status_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_IDLE) |=> reg_rdata[BIT_STOP])
    else $error("status bit not idle after idle state");
  stop_halt_a: assert property (@(posedge clk_sys) disable iff (rst)
    stop_write |=> (state_q == ST_IDLE) && !adc_power_on)
    else $error("stop did not halt and power down");
  invalid_func_a: assert property (@(posedge clk_sys) disable iff (rst)
    result_we |-> func_q != FN_INVALID)
    else $error("result written under invalid function");
  xy_results_a: assert property (@(posedge clk_sys) disable iff (rst)
    result_we && func_q == FN_XY |-> result_sel inside {CH_X, CH_Y})
    else $error("xy scan wrote a foreign result");
  port_results_a: assert property (@(posedge clk_sys) disable iff (rst)
    result_we && func_q == FN_PORT |-> result_sel inside
      {CH_BATTERY_ONE_RESULT, CH_BATTERY_TWO_RESULT, CH_AUXILIARY_ONE_RESULT, CH_AUXILIARY_TWO_RESULT})
    else $error("port scan wrote a foreign result");
  panel_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_IDLE && !reg_wr && func_q == FN_DRV_X && !stop_q
    |=> drv_xp && drv_xm && !drv_yp && !drv_ym)
    else $error("x drivers not enabled");
  settle_first_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(state_q == ST_CONV) && $past(state_q) == ST_IDLE
    |-> !drive_ch(chan_q))
    else $error("panel conversion skipped settling");
  avg_busy_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_CONV && navg_q != avg_last && !reg_wr
    |=> !result_we && !result_available_output)
    else $error("idle before averaging finished");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rdata[0])
    else $error("reserved bit reads one");
  field_readback_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr ##1 !reg_wr |=> reg_rdata[13:1] == $past(reg_wdata[13:1], 2))
    else $error("fields do not read back");
  single_shot_a: assert property (@(posedge clk_sys) disable iff (rst)
    result_we && func_q == FN_BATTERY_ONE_RESULT |-> state_q == ST_IDLE)
    else $error("single shot did not return idle");
endmodule // touch_adc_control_sequencer

// *** host_model.sv ***
/*
  Host-side partner of the converter sequencer: writes whole control
  words and supplies the analog sample and pen pin.
  Assumes the bench clock and a design that takes writes on reg_wr.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk_sys,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  output logic             pen_touch_in,
  output logic      [11:0] sample_in
);
  initial begin
    reg_wr       = 1'b0;
    reg_wdata    = 16'h0000;
    pen_touch_in = 1'b0;
    sample_in    = 12'hABC;
  end

  // fast clock only with low resolution.
  // Callers use 8 MHz only with 8-bit words and 4 MHz only with 10-bit
  // words, so every result is defined.
  task automatic put_word(input logic [15:0] w);
    @(posedge clk_sys);
    #1;
    reg_wr    = 1'b1;
    reg_wdata = w;
    @(posedge clk_sys);
    #1;
    reg_wr    = 1'b0;
  endtask

  // Pin and sample changes land just after an edge, like every input.
  task automatic set_pen(input logic v);
    @(posedge clk_sys);
    #1;
    pen_touch_in = v;
  endtask

  task automatic set_sample(input logic [11:0] v);
    @(posedge clk_sys);
    #1;
    sample_in = v;
  endtask
endmodule // host_model

// *** touch_adc_control_sequencer_tb.sv ***
/*
  Self-checking bench for the converter sequencer.
  Assumes the host model as partner and a shortened first settling parameter.
*/
`timescale 1ns/1ps
module touch_adc_control_sequencer_tb;
  import touch_adc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        reg_wr, pen_touch_in, adc_power_on, result_we;
  logic [15:0] reg_wdata, reg_rdata;
  logic [11:0] sample_in, result_data;
  logic        result_available_output;
  logic        drv_xp, drv_xm, drv_yp, drv_ym;
  channel_t    conv_channel, result_sel;
  int          err_count  = 0;
  int          num_checks = 0;

  always #2.5 clk_sys = ~clk_sys;

  touch_adc_control_sequencer #(
    .SETTLE_CYC_P1(10)
  ) u_touch_adc_control_sequencer (
    .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pen_touch_in(pen_touch_in), .sample_in(sample_in),
    .conv_channel(conv_channel), .adc_power_on(adc_power_on),
    .result_available_output(result_available_output),
    .result_we(result_we), .result_sel(result_sel),
    .result_data(result_data), .drv_xp(drv_xp), .drv_xm(drv_xm),
    .drv_yp(drv_yp), .drv_ym(drv_ym)
  );

  host_model u_host_model (
    .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .pen_touch_in(pen_touch_in), .sample_in(sample_in)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Waits a bounded time for one result strobe, then judges it.
  task automatic get_result(input channel_t sel, input logic [11:0] dat);
    int i;
    for (i = 0; i < 6000 && result_we !== 1'b1; i++) tick(1);
    chk("result_we", 16'h0001, 16'(result_we));
    chk("result_sel", 16'(sel), 16'(result_sel));
    chk("result_data", 16'(dat), 16'(result_data));
    // Step past the strobe so a following call waits for a fresh one.
    tick(1);
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic t_single;
    u_host_model.put_word(16'h1900);
    tick(3);
    chk("status busy", 16'h0000, 16'(reg_rdata[14]));
    get_result(CH_BATTERY_ONE_RESULT, 12'h0AB);
    tick(2);
    chk("status idle", 16'h0001, 16'(reg_rdata[14]));
    u_host_model.put_word(16'h1D00);
    get_result(CH_BATTERY_TWO_RESULT, 12'h0AB);
    u_host_model.put_word(16'h2100);
    get_result(CH_AUXILIARY_ONE_RESULT, 12'h0AB);
    u_host_model.put_word(16'h2820);
    get_result(CH_TEMP1, 12'hABC);
    u_host_model.put_word(16'h3210);
    get_result(CH_TEMP2, 12'h2AF);
  endtask

  task automatic t_stop;
    u_host_model.put_word(16'h1900);
    tick(10);
    u_host_model.put_word(16'h5900);
    tick(1);
    chk("power after stop", 16'h0000, 16'(adc_power_on));
    repeat (400) begin
      tick(1);
      chk("no result", 16'h0000, 16'(result_we));
    end
  endtask

  task automatic t_avg;
    u_host_model.put_word(16'h1940);
    tick(1000);
    chk("avg busy", 16'h0000, 16'(result_available_output));
    get_result(CH_BATTERY_ONE_RESULT, 12'h0AB);
    u_host_model.put_word(16'h19C0);
    get_result(CH_BATTERY_ONE_RESULT, 12'h0AB);
  endtask

  task automatic t_drivers;
    logic [3:0] exp [3] = '{4'hC, 4'h3, 4'h6};
    for (int k = 0; k < 3; k++) begin
      u_host_model.put_word({2'b00, 4'(FN_DRV_X + k), 10'h100});
      tick(3);
      chk("drivers", 16'(exp[k]),
          16'({drv_xp, drv_xm, drv_yp, drv_ym}));
    end
  endtask

  task automatic t_scan_readback;
    u_host_model.put_word(16'h2D00);
    get_result(CH_BATTERY_ONE_RESULT, 12'h0AB);
    tick(1);
    get_result(CH_BATTERY_TWO_RESULT, 12'h0AB);
    tick(1);
    get_result(CH_AUXILIARY_ONE_RESULT, 12'h0AB);
    tick(1);
    get_result(CH_AUXILIARY_TWO_RESULT, 12'h0AB);
    u_host_model.put_word(16'h7FFF);
    tick(3);
    chk("readback", 16'h7FFE, reg_rdata);
    chk("drivers off", 16'h0000,
        16'({drv_xp, drv_xm, drv_yp, drv_ym}));
  endtask

  task automatic t_scan;
    u_host_model.set_sample(12'h5A3);
    u_host_model.set_pen(1'b1);
    u_host_model.put_word(16'h0500);
    tick(5);
    chk("x drivers", 16'h000C,
        16'({drv_xp, drv_xm, drv_yp, drv_ym}));
    get_result(CH_X, 12'h05A);
    get_result(CH_Y, 12'h05A);
    get_result(CH_X, 12'h05A);
    u_host_model.set_pen(1'b0);
    get_result(CH_Y, 12'h05A);
    tick(2);
    chk("scan ends", 16'h0001, 16'(result_available_output));
    u_host_model.put_word(16'h0900);
    get_result(CH_X, 12'h05A);
    get_result(CH_Y, 12'h05A);
    get_result(CH_Z1, 12'h05A);
    get_result(CH_Z2, 12'h05A);
  endtask

  task automatic t_self;
    u_host_model.put_word(16'h8502);
    tick(10);
    chk("self waits", 16'h0000, 16'(adc_power_on));
    u_host_model.set_pen(1'b1);
    tick(8);
    chk("settle drive", 16'h000C,
        16'({drv_xp, drv_xm, drv_yp, drv_ym}));
    chk("pen flag", 16'h0001, 16'(reg_rdata[15]));
    get_result(CH_X, 12'h05A);
    u_host_model.set_pen(1'b0);
    get_result(CH_Y, 12'h05A);
    tick(2);
    chk("self idle", 16'h0001, 16'(result_available_output));
    u_host_model.put_word(16'h4000);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    tick(1);
    chk("reset word", 16'h4000, reg_rdata);
    chk("reset idle", 16'h0001, 16'(result_available_output));
    t_single();
    t_stop();
    t_avg();
    t_drivers();
    t_scan_readback();
    t_scan();
    t_self();
    close_out();
  end

  // The scenarios need about 14000 cycles; the rest is margin.
  initial begin
    repeat (25000) @(posedge clk_sys);
    err_count++;
    close_out();
  end
endmodule // touch_adc_control_sequencer_tb
